// file: rtl/mphc_top.sv
`timescale 1ns/1ps
`include "mphc_consts.svh"
// What this block does
// - direction setting 0 maps forward generator to ccw; 1 swaps directions.
// - both multiplier inputs off means factor comes from the multiplier parameter.
// - inputs low-only give x1, high-only x10, both x100.
// - parameter value 0 gives x1, 1 gives x10, 2 gives x100.
// - in manual mode each scaled generator pulse becomes a position command.
// - generator commands are added to a running jog command, not dropped.
// - home is unknown after power-on; operator must home before positioning.
// - homing started on the dog first retracts off the dog.
// - dog type decelerates at dog front, homes at first z after rear plus shift.
// - count type decelerates at front, travels set distance, homes at next z plus shift.
// - data-set type takes present position as home without dog.
// - stopper type pushes to stop, stall position is home; keep speed low.
// - homing direction 0 moves toward increasing address, 1 toward decreasing.
// - dog polarity 0 detects dog on input off, 1 on input on.
module mphc_top
  import mphc_pkg::*;
#(
  parameter int POS_W        = 32,
  parameter int STALL_CYCLES = `MPHC_STALL_CYCLES
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // generator pins
  input  wire logic             i_gen_a,
  input  wire logic             i_gen_b,
  // mode and multiplier
  input  wire logic             i_operation_mode_select,
  input  wire logic [4:0]       i_point_select,
  input  wire logic             i_multiplier_select_low,
  input  wire logic             i_multiplier_select_high,
  input  wire logic [1:0]       i_generator_multiplier_param,
  input  wire logic             i_rotation_direction_select,
  // jog
  input  wire logic             i_jog_step,
  input  wire logic             i_jog_dir,
  // homing configuration
  input  wire logic [1:0]       i_homing_type_param,
  input  wire logic             i_homing_dir_param,
  input  wire logic             i_dog_polarity_param,
  input  wire logic [POS_W-1:0] i_home_shift,
  input  wire logic [POS_W-1:0] i_travel_after_dog,
  input  wire logic             i_home_start,
  // motor feedback
  input  wire logic             i_prox_dog,
  input  wire logic             i_enc_z,
  input  wire logic             i_torque_limit,
  input  wire logic             i_zero_speed,
  input  wire logic             i_motion_step,
  // outputs
  output logic [POS_W-1:0]      o_pos_cmd,
  output logic                  o_home_valid,
  output logic                  o_homing_busy,
  output logic                  o_home_move_req,
  output logic                  o_home_move_dir,
  output logic                  o_home_decel,
  output logic                  o_manual_mode
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // a x100 step needs headroom in the accumulator, and the stall timer at least one cycle
  if (POS_W < 16 || STALL_CYCLES < 1) begin : g_bad_param
    $error("mphc_top: bad parameter");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  wire  [NSYNC-1:0] raw_w = {i_gen_a, i_gen_b, i_prox_dog, i_enc_z, i_torque_limit, i_zero_speed};

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end

  wire gen_a_w  = sync_q[5];
  wire gen_b_w  = sync_q[4];
  wire dog_in_w = sync_q[3];
  wire z_w      = sync_q[2];
  wire tlim_w   = sync_q[1];
  wire zspd_w   = sync_q[0];
  // polarity 0: dog seen when the input is off
  wire dog_hit_w = i_dog_polarity_param ? dog_in_w : ~dog_in_w;

  // ----------------------------------------
  // quadrature decode
  // ----------------------------------------
  logic [1:0] ab_q;
  logic       z_prev_q;
  logic       dog_prev_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ab_q       <= 2'h0;
      z_prev_q   <= 1'b0;
      dog_prev_q <= 1'b0;
    end else begin
      ab_q       <= {gen_a_w, gen_b_w};
      z_prev_q   <= z_w;
      dog_prev_q <= dog_hit_w;
    end
  end

  // returns +1, -1 or 0 from the old and new a/b states; skipped steps count as 0
  function automatic logic signed [1:0] mphc_quad(input logic [1:0] prev, input logic [1:0] curr);
    logic [3:0] code;
    code = {prev, curr};
    case (code)
      4'h1, 4'h7, 4'he, 4'h8: mphc_quad = 2'sd1;
      4'h2, 4'hb, 4'hd, 4'h4: mphc_quad = -2'sd1;
      default:                mphc_quad = 2'sd0;
    endcase
  endfunction : mphc_quad

  wire logic signed [1:0] quad_w = mphc_quad(ab_q, {gen_a_w, gen_b_w});

  // ----------------------------------------
  // multiplier selection
  // ----------------------------------------
  function automatic logic [7:0] mphc_param_factor(input logic [1:0] code);
    case (code)
      `MPHC_PARAM_X10:  mphc_param_factor = `MPHC_FACTOR_X10;
      `MPHC_PARAM_X100: mphc_param_factor = `MPHC_FACTOR_X100;
      default:          mphc_param_factor = `MPHC_FACTOR_X1;
    endcase
  endfunction : mphc_param_factor

  wire [1:0] sel_w    = {i_multiplier_select_high, i_multiplier_select_low};
  wire [7:0] factor_w = (sel_w == 2'h0) ? mphc_param_factor(i_generator_multiplier_param) :
                        (sel_w == 2'h1) ? `MPHC_FACTOR_X1 :
                        (sel_w == 2'h2) ? `MPHC_FACTOR_X10 : `MPHC_FACTOR_X100;

  // ----------------------------------------
  // position command
  // ----------------------------------------
  // mode select off is manual; point selects are simply not read here
  wire manual_w = ~i_operation_mode_select;
  // setting 1 inverts the generator's sense of rotation
  wire signed [1:0] gen_dir_w = i_rotation_direction_select ? -quad_w : quad_w;
  wire signed [POS_W-1:0] gen_delta_w = POS_W'($signed(gen_dir_w) * $signed({1'b0, factor_w}));
  wire signed [POS_W-1:0] jog_delta_w = !i_jog_step ? '0 :
                                        (i_jog_dir ^ i_rotation_direction_select) ? -POS_W'(1) : POS_W'(1);

  typedef logic [POS_W-1:0] pos_t;
  pos_t pos_q;
  wire  pos_t man_next_w = pos_q + pos_t'(gen_delta_w) + pos_t'(jog_delta_w);

  // ----------------------------------------
  // homing edge detect and direction
  // ----------------------------------------
  wire dog_front_w = dog_hit_w & ~dog_prev_q;
  wire dog_rear_w  = ~dog_hit_w & dog_prev_q;
  wire z_rise_w    = z_w & ~z_prev_q;
  // with dir 0 the move steps toward increasing address
  wire signed [POS_W-1:0] step_w = i_homing_dir_param ? -POS_W'(1) : POS_W'(1);

  // ----------------------------------------
  // homing state
  // ----------------------------------------
  mphc_state_t st_q;
  mphc_state_t st_d;
  pos_t        travel_q;
  logic [31:0] stall_q;
  logic [1:0]  type_q;
  logic        home_valid_q;

  // state decodes shared by the sequencer, the position select and the outputs
  wire in_idle_w    = (st_q == MPHC_IDLE);
  wire in_retract_w = (st_q == MPHC_RETRACT);
  wire in_seek_z_w  = (st_q == MPHC_SEEK_Z);
  wire in_stall_w   = (st_q == MPHC_STALL_WAIT);
  wire in_travel_w  = (st_q == MPHC_COUNT_TRAVEL);
  wire homing_w     = ~in_idle_w & (st_q != MPHC_DONE);
  // creep from the dog front until home is taken
  wire creep_w      = (st_q == MPHC_ON_DOG) | in_travel_w | in_seek_z_w;

  // a start is only taken in idle and outside manual mode
  wire start_w       = in_idle_w & i_home_start & ~manual_w;
  wire count_type_w  = (type_q == `MPHC_HOME_COUNT);
  wire travel_done_w = (travel_q >= i_travel_after_dog);
  wire stall_cond_w  = tlim_w & zspd_w;
  wire stall_hit_w   = (stall_q >= 32'(STALL_CYCLES - 1)) & stall_cond_w;

  // ----------------------------------------
  // homing sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      MPHC_IDLE: begin
        if (start_w) begin
          case (i_homing_type_param)
            `MPHC_HOME_DATASET: st_d = MPHC_DONE;
            `MPHC_HOME_STOPPER: st_d = MPHC_STALL_WAIT;
            default:            st_d = dog_hit_w ? MPHC_RETRACT : MPHC_SEEK_DOG;
          endcase
        end
      end
      // back off opposite the homing direction until the dog is clear
      MPHC_RETRACT: begin
        if (!dog_hit_w) st_d = MPHC_SEEK_DOG;
      end
      MPHC_SEEK_DOG: begin
        if (dog_front_w) st_d = MPHC_ON_DOG;
      end
      // count type only starts its travel once the dog has been passed
      MPHC_ON_DOG: begin
        if (dog_rear_w) st_d = count_type_w ? MPHC_COUNT_TRAVEL : MPHC_SEEK_Z;
      end
      MPHC_COUNT_TRAVEL: begin
        if (travel_done_w) st_d = MPHC_SEEK_Z;
      end
      MPHC_SEEK_Z: begin
        if (z_rise_w) st_d = MPHC_DONE;
      end
      MPHC_STALL_WAIT: begin
        if (stall_hit_w) st_d = MPHC_DONE;
      end
      MPHC_DONE: begin
        st_d = MPHC_IDLE;
      end
      default: begin
        st_d = MPHC_IDLE;
      end
    endcase
    // dropping to manual mode abandons a return; home stays unknown
    if (manual_w && homing_w) st_d = MPHC_IDLE;
  end

  // ----------------------------------------
  // position select
  // ----------------------------------------
  // entering done is the one moment home is taken, whatever the type
  wire       home_set_w = (st_d == MPHC_DONE);
  // the shift is loaded at the z edge so dog and count types share one path;
  // data-set and stopper types take zero where they stand
  wire pos_t home_pos_w = in_seek_z_w ? i_home_shift : '0;
  wire pos_t move_w     = in_retract_w ? pos_t'(-step_w) : pos_t'(step_w);
  wire pos_t pos_d      = home_set_w ? home_pos_w :
                          manual_w ? man_next_w :
                          (homing_w & i_motion_step) ? pos_q + move_w : pos_q;

  // ----------------------------------------
  // homing registers
  // ----------------------------------------
  // the stall timer restarts whenever torque limit or zero speed drops out
  wire [31:0] stall_d  = (in_stall_w & stall_cond_w & ~stall_hit_w) ? stall_q + 32'h1 : 32'h0;
  wire pos_t  travel_d = in_travel_w ? travel_q + pos_t'(i_motion_step) : '0;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_q         <= MPHC_IDLE;
      pos_q        <= '0;
      travel_q     <= '0;
      stall_q      <= '0;
      type_q       <= 2'h0;
      home_valid_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      pos_q    <= pos_d;
      travel_q <= travel_d;
      stall_q  <= stall_d;
      if (in_idle_w) type_q <= i_homing_type_param;
      if (home_set_w) home_valid_q <= 1'b1;
      else if (start_w) home_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pos_cmd       <= '0;
      o_home_valid    <= 1'b0;
      o_homing_busy   <= 1'b0;
      o_home_move_req <= 1'b0;
      o_home_move_dir <= 1'b0;
      o_home_decel    <= 1'b0;
      o_manual_mode   <= 1'b0;
    end else begin
      o_pos_cmd       <= pos_q;
      o_home_valid    <= home_valid_q;
      o_homing_busy   <= homing_w;
      o_home_move_req <= homing_w;
      o_home_move_dir <= in_retract_w ? ~i_homing_dir_param : i_homing_dir_param;
      // once the dog front is met the controller slows to creep speed
      o_home_decel    <= creep_w;
      o_manual_mode   <= manual_w;
    end
  end

endmodule : mphc_top

// file: include/mphc_consts.svh
`ifndef MPHC_CONSTS_SVH
`define MPHC_CONSTS_SVH
// ----------------------------------------
// multiplier codes and factors
// ----------------------------------------
`define MPHC_FACTOR_X1      8'h01
`define MPHC_FACTOR_X10     8'h0a
`define MPHC_FACTOR_X100    8'h64
`define MPHC_PARAM_X1       2'h0
`define MPHC_PARAM_X10      2'h1
`define MPHC_PARAM_X100     2'h2
// ----------------------------------------
// homing type codes
// ----------------------------------------
`define MPHC_HOME_DOG       2'h0
`define MPHC_HOME_COUNT     2'h1
`define MPHC_HOME_DATASET   2'h2
`define MPHC_HOME_STOPPER   2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define MPHC_CLOCK_HZ       50000000
`define MPHC_STALL_TIME_MS  100
`define MPHC_STALL_CYCLES   ((`MPHC_CLOCK_HZ / 1000) * `MPHC_STALL_TIME_MS)
`endif

// file: include/mphc_pkg.sv
package mphc_pkg;
  typedef enum logic [2:0] {
    MPHC_IDLE,
    MPHC_RETRACT,
    MPHC_SEEK_DOG,
    MPHC_ON_DOG,
    MPHC_COUNT_TRAVEL,
    MPHC_SEEK_Z,
    MPHC_STALL_WAIT,
    MPHC_DONE
  } mphc_state_t;
endpackage : mphc_pkg

// file: bench/mphc_chk.sv
`timescale 1ns/1ps
module mphc_chk #(
  parameter int POS_W        = 32,
  parameter int STALL_CYCLES = 8
) (
  // watched ports
  input wire logic             i_clock,
  input wire logic             i_rst_b,
  input wire logic             i_operation_mode_select,
  input wire logic             i_homing_dir_param,
  input wire logic             i_home_start,
  input wire logic [POS_W-1:0] o_pos_cmd,
  input wire logic             o_home_valid,
  input wire logic             o_homing_busy,
  input wire logic             o_home_move_req,
  input wire logic             o_home_move_dir,
  input wire logic             o_home_decel,
  input wire logic             o_manual_mode
);
  logic [POS_W-1:0]        prev_q;
  logic                    man_q;
  wire signed [POS_W-1:0]  step_w = o_pos_cmd - prev_q;
  always_ff @(posedge i_clock) begin
    prev_q <= o_pos_cmd;
    man_q  <= o_manual_mode;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_reset_clear: assert property (disable iff (1'b0) !i_rst_b |=> o_pos_cmd == '0 && !o_home_valid && !o_homing_busy)
    else $error("outputs not cleared by reset");
  // one cycle may carry a generator step and a jog step together
  a_pos_step: assert property (o_manual_mode && man_q |-> step_w inside {0, 1, 2, 9, 10, 11, 99, 100, 101,
    -1, -2, -9, -10, -11, -99, -100, -101}) else $error("position step not a legal factor");
  a_mode_follow: assert property ($fell(i_operation_mode_select) |=> o_manual_mode)
    else $error("manual mode not entered");
  a_move_fresh: assert property ($rose(o_home_move_req) |-> !o_home_valid)
    else $error("home valid at move start");
  a_decel_busy: assert property (o_home_decel |-> o_homing_busy) else $error("creep outside homing");
  a_decel_dir: assert property (o_home_decel |-> o_home_move_dir == i_homing_dir_param)
    else $error("creep in wrong direction");
  a_valid_clear: assert property (o_home_move_req && $past(o_home_move_req) |-> !o_home_valid)
    else $error("home valid while moving");
  a_valid_hold: assert property (o_home_valid && !i_home_start |=> o_home_valid || o_homing_busy)
    else $error("home lost without restart");
endmodule : mphc_chk
bind mphc_top mphc_chk #(.POS_W(POS_W), .STALL_CYCLES(STALL_CYCLES)) u_chk (.i_clock(i_clock),
  .i_rst_b(i_rst_b), .i_operation_mode_select(i_operation_mode_select), .i_homing_dir_param(i_homing_dir_param),
  .i_home_start(i_home_start), .o_pos_cmd(o_pos_cmd), .o_home_valid(o_home_valid), .o_homing_busy(o_homing_busy),
  .o_home_move_req(o_home_move_req), .o_home_move_dir(o_home_move_dir), .o_home_decel(o_home_decel),
  .o_manual_mode(o_manual_mode));

// file: bench/mphc_partner.sv
`timescale 1ns/1ps
module mphc_partner (
  // controls from bench and design
  input  wire logic i_clock,
  input  wire logic i_gen_step,
  input  wire logic i_gen_fwd,
  input  wire logic i_move_req,
  input  wire logic i_move_dir,
  input  wire logic i_dog_pol,
  input  wire logic i_load,
  input  wire logic [31:0] i_load_pos,
  // sensors
  output logic      o_gen_a,
  output logic      o_gen_b,
  output logic      o_prox_dog,
  output logic      o_enc_z,
  output logic      o_stall,
  output logic      o_motion_step
);
  int         pos = 0;
  logic [1:0] ph  = 2'h0;
  logic [1:0] div = 2'h0;
  wire        on_dog = pos >= 40 && pos <= 60;
  initial o_motion_step = 1'b0;
  // a leads b when turned forward
  assign {o_gen_a, o_gen_b} = {ph[1] ^ ph[0], ph[1]};
  assign o_prox_dog = on_dog ~^ i_dog_pol;
  assign o_enc_z = pos % 16 == 0;
  assign o_stall = i_move_req && pos <= -30;
  always @(posedge i_clock) begin
    o_motion_step <= 1'b0;
    div <= div + 2'h1;
    if (i_gen_step) ph <= i_gen_fwd ? ph + 2'h1 : ph - 2'h1;
    if (i_load) pos <= i_load_pos;
    else if (i_move_req && div == 2'h0 && !o_stall) begin
      o_motion_step <= 1'b1;
      pos <= i_move_dir ? pos - 1 : pos + 1;
    end
  end
endmodule : mphc_partner

// file: bench/mphc_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module mphc_top_bench;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        stp = 1'b0, fwd = 1'b0, mode = 1'b0, mlo = 1'b0, mhi = 1'b0, rot = 1'b0;
  logic        jog = 1'b0, jdir = 1'b0, hdir = 1'b0, pol = 1'b0, hst = 1'b0;
  logic [1:0]  mpar = 2'h0, htyp = 2'h0;
  logic [4:0]  psel = 5'h00;
  logic [31:0] shift = 32'h0, pos;
  logic        ga, gb, dog, z, stall, mstep, hv, busy, mreq, mdir, dec, man;
  int          fails = 0, cmp_count = 0;
  logic        ld = 1'b0;
  int          ld_pos = 0;
  always #10 i_clock = ~i_clock;
  mphc_top #(.POS_W(32), .STALL_CYCLES(8)) DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_gen_a(ga), .i_gen_b(gb),
    .i_operation_mode_select(mode), .i_point_select(psel), .i_multiplier_select_low(mlo),
    .i_multiplier_select_high(mhi), .i_generator_multiplier_param(mpar), .i_rotation_direction_select(rot),
    .i_jog_step(jog), .i_jog_dir(jdir), .i_homing_type_param(htyp), .i_homing_dir_param(hdir),
    .i_dog_polarity_param(pol), .i_home_shift(shift), .i_travel_after_dog(32'h1e), .i_home_start(hst),
    .i_prox_dog(dog), .i_enc_z(z), .i_torque_limit(stall), .i_zero_speed(stall), .i_motion_step(mstep),
    .o_pos_cmd(pos), .o_home_valid(hv), .o_homing_busy(busy), .o_home_move_req(mreq),
    .o_home_move_dir(mdir), .o_home_decel(dec), .o_manual_mode(man));
  mphc_partner u_far (.i_clock(i_clock), .i_gen_step(stp), .i_gen_fwd(fwd), .i_move_req(mreq),
    .i_move_dir(mdir), .i_dog_pol(pol), .i_load(ld), .i_load_pos(ld_pos),
    .o_gen_a(ga), .o_gen_b(gb), .o_prox_dog(dog), .o_enc_z(z),
    .o_stall(stall), .o_motion_step(mstep));
  function automatic int factor(input logic lo, input logic hi, input logic [1:0] p);
    if (hi) return lo ? 100 : 10;
    if (lo) return 1;
    return p == 2'h1 ? 10 : (p == 2'h2 ? 100 : 1);
  endfunction : factor
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic stop_test;
    $display("compares %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    #(20 * 20000);
    fails++;
    stop_test();
  end
  initial begin
    int   ep;
    int   d;
    logic sr;
    logic sd;
    void'($urandom(32'hb70ca817));
    tick(10);
    i_rst_b = 1'b1;
    tick(3);
    `CHK(pos, 32'h0)
    `CHK(hv, 1'b0)
    `CHK(man, 1'b1)
    ep = 0;
    // ----------------------------------------
    // generator steps, first twelve walk every select code
    // ----------------------------------------
    for (int k = 0; k < 48; k++) begin
      {mhi, mlo} = k < 12 ? k[1:0] : 2'($urandom);
      mpar = k < 12 ? k[3:2] : 2'($urandom);
      {rot, fwd, jdir} = 3'($urandom);
      psel = 5'($urandom);
      d = (fwd ^ rot) ? -factor(mlo, mhi, mpar) : factor(mlo, mhi, mpar);
      if (k % 3 == 0) d += (jdir ^ rot) ? -1 : 1;
      stp = 1'b1;
      jog = k % 3 == 0;
      tick(1);
      stp = 1'b0;
      jog = 1'b0;
      tick(6);
      ep += d;
      `CHK(pos, ep[31:0])
    end
    mode = 1'b1;
    tick(3);
    `CHK(man, 1'b0)
    stp = 1'b1;
    jog = 1'b1;
    tick(1);
    stp = 1'b0;
    jog = 1'b0;
    tick(6);
    `CHK(pos, ep[31:0])
    // ----------------------------------------
    // each homing type; dog type starts on the dog
    // ----------------------------------------
    for (int h = 0; h < 4; h++) begin
      htyp = 2'(h);
      hdir = h == 3;
      pol = h != 0;
      shift = $urandom;
      ld_pos = (h == 0) ? 50 : 0;
      ld = 1'b1;
      sr = 1'b0;
      sd = 1'b0;
      tick(1);
      ld = 1'b0;
      // let the new dog level and polarity settle through the synchronisers first
      tick(3);
      hst = 1'b1;
      tick(1);
      hst = 1'b0;
      tick(3);
      for (int n = 0; n < 3000 && !(hv === 1'b1 && busy === 1'b0); n++) begin
        sr |= mreq && mdir !== hdir;
        sd |= dec;
        tick(1);
      end
      `CHK(hv, 1'b1)
      `CHK(pos, h < 2 ? shift : 32'h0)
      if (h == 0) `CHK(sr, 1'b1)
      if (h < 2) `CHK(sd, 1'b1)
    end
    // ----------------------------------------
    // back to manual mode after homing
    // ----------------------------------------
    mode = 1'b0;
    mhi = 1'b1;
    mlo = 1'b0;
    {rot, fwd} = 2'($urandom);
    tick(3);
    `CHK(man, 1'b1)
    stp = 1'b1;
    tick(1);
    stp = 1'b0;
    tick(6);
    `CHK(pos, (fwd ^ rot) ? -32'h0000000a : 32'h0000000a)
    stop_test();
  end
endmodule : mphc_top_bench
